// File: verification/tb_block_cipher_register_interface.sv
// Self-checking bench for the block cipher register interface.
// Assumes bc_pkg and bc_core are compiled first; drives the register
// port directly and uses a known 128-bit cipher vector pair.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_fail++; \
  $display("unexpected %s: expected %h seen %h", nm, ex, got); end end
module tb_block_cipher_register_interface
  import bc_pkg::*;
;
  // ------------------------------------------------------------
  // Signals and vectors
  // ------------------------------------------------------------
  logic       ref_clk = 1'b0;
  logic       rst_n;
  logic [8:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       sleep_enter;
  logic       irq;
  int         n_fail;
  int         checks;
  // Byte 0 sits in the top bits of each vector
  localparam logic [127:0] KEY_V = 128'h000102030405060708090A0B0C0D0E0F;
  localparam logic [127:0] PT_V  = 128'h00112233445566778899AABBCCDDEEFF;
  localparam logic [127:0] CT_V  = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
  localparam logic [127:0] RK_V  = 128'h13111D7FE3944A17F307A78B4D2B30C5;

  bc_core dut (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .reg_addr    (reg_addr),
    .reg_wdata   (reg_wdata),
    .reg_wr      (reg_wr),
    .reg_rd      (reg_rd),
    .reg_rdata   (reg_rdata),
    .sleep_enter (sleep_enter),
    .irq         (irq)
  );

  // Free-running 250 MHz clock
  always #2 ref_clk = ~ref_clk;

  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  // One write cycle, strobe dropped on the taking edge
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the taking edge
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic rd_chk(input logic [8:0] a, input logic [7:0] ex, input string nm);
    logic [7:0] d;
    rd(a, d);
    `CHK(nm, ex, d)
  endtask

  // Sixteen accesses to one address, byte 0 first
  task automatic load(input logic [8:0] a, input logic [127:0] b);
    for (int i = 0; i < 16; i++) begin
      wr(a, b[127-8*i -: 8]);
    end
  endtask

  task automatic unload(input logic [8:0] a, input logic [127:0] b, input string nm);
    for (int i = 0; i < 16; i++) begin
      rd_chk(a, b[127-8*i -: 8], nm);
    end
  endtask

  // Poll status until a flag shows; a run is ten rounds long
  task automatic wait_end();
    logic [7:0] d;
    for (int i = 0; i < 40; i++) begin
      rd(BC_STAT_ADR, d);
      if (d != 8'h00) begin
        return;
      end
    end
    n_fail++;
    $display("unexpected status poll: no end of run seen");
    tally_and_finish();
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    reg_addr = 9'h000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sleep_enter = 1'b0;
    n_fail = 0;
    checks = 0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;

    // Reset values, read-only status, writable control bits, unmapped place
    rd_chk(BC_CTRL_ADR, 8'h00, "ctrl reset");
    rd_chk(BC_STAT_ADR, 8'h00, "status reset");
    wr(BC_STAT_ADR, 8'hFF);
    rd_chk(BC_STAT_ADR, 8'h00, "status after write");
    wr(BC_CTRL_ADR, 8'h2C);
    rd_chk(BC_CTRL_ADR, 8'h2C, "ctrl writable bits");
    rd_chk(9'h150, 8'h00, "unmapped read");
    `CHK("irq idle", 1'b0, irq)
    $display("test reset_values done");

    // Start with nothing loaded: error, interrupt, clear
    wr(BC_IMASK_ADR, 8'h03);
    wr(BC_CTRL_ADR, 8'h84);
    wait_end();
    rd_chk(BC_STAT_ADR, 8'h80, "status start error");
    rd_chk(BC_ISTAT_ADR, 8'h02, "istat start error");
    `CHK("irq start error", 1'b1, irq)
    wr(BC_ISTAT_ADR, 8'h02);
    rd_chk(BC_ISTAT_ADR, 8'h00, "istat cleared");
    `CHK("irq cleared", 1'b0, irq)
    $display("test start_error done");

    // Code book encryption with interrupt disabled
    load(BC_KEY_ADR, KEY_V);
    load(BC_TEXT_ADR, PT_V);
    wr(BC_CTRL_ADR, 8'h80);
    wait_end();
    rd_chk(BC_STAT_ADR, 8'h01, "status done");
    `CHK("irq disabled", 1'b0, irq)
    rd_chk(BC_ISTAT_ADR, 8'h00, "istat disabled");
    unload(BC_TEXT_ADR, CT_V, "ecb ciphertext");
    unload(BC_KEY_ADR, RK_V, "last round key");
    $display("test ecb_encrypt done");

    // Same key reused without reloading
    load(BC_TEXT_ADR, PT_V);
    wr(BC_CTRL_ADR, 8'h80);
    wait_end();
    rd_chk(BC_STAT_ADR, 8'h01, "status rerun");
    unload(BC_TEXT_ADR, CT_V, "rerun ciphertext");
    $display("test key_reuse done");

    // Code book decryption with the round key, interrupt on success
    load(BC_KEY_ADR, RK_V);
    load(BC_TEXT_ADR, CT_V);
    wr(BC_CTRL_ADR, 8'h8C);
    wait_end();
    rd_chk(BC_STAT_ADR, 8'h01, "status decrypt");
    rd_chk(BC_ISTAT_ADR, 8'h01, "istat done");
    `CHK("irq done", 1'b1, irq)
    wr(BC_ISTAT_ADR, 8'h01);
    unload(BC_TEXT_ADR, PT_V, "ecb plaintext");
    $display("test ecb_decrypt done");

    // Control access in mid-run aborts it
    load(BC_TEXT_ADR, PT_V);
    wr(BC_CTRL_ADR, 8'h84);
    rd_chk(BC_CTRL_ADR, 8'h84, "ctrl while running");
    rd_chk(BC_STAT_ADR, 8'h80, "status abort");
    rd_chk(BC_STAT_ADR, 8'h80, "status stays aborted");
    rd_chk(BC_ISTAT_ADR, 8'h02, "istat abort");
    `CHK("irq abort", 1'b1, irq)
    wr(BC_ISTAT_ADR, 8'h03);
    rd_chk(BC_CTRL_ADR, 8'h04, "ctrl after abort");
    $display("test abort done");

    // Start before the result was read back: error, no interrupt
    wr(BC_CTRL_ADR, 8'h80);
    wait_end();
    rd_chk(BC_STAT_ADR, 8'h80, "status short readout");
    rd_chk(BC_ISTAT_ADR, 8'h00, "istat short readout");
    `CHK("irq short readout", 1'b0, irq)
    $display("test short_readout done");

    // Sleep entry clears control, status and both buffers
    @(posedge ref_clk);
    sleep_enter <= 1'b1;
    @(posedge ref_clk);
    sleep_enter <= 1'b0;
    rd_chk(BC_CTRL_ADR, 8'h00, "ctrl after sleep");
    rd_chk(BC_STAT_ADR, 8'h00, "status after sleep");
    unload(BC_TEXT_ADR, 128'h0, "text after sleep");
    unload(BC_KEY_ADR, 128'h0, "key after sleep");
    wr(BC_CTRL_ADR, 8'h80);
    wait_end();
    rd_chk(BC_STAT_ADR, 8'h80, "key cleared by sleep");
    $display("test sleep done");

    // Chaining: first block equals code book, decrypt folds in chain
    load(BC_KEY_ADR, KEY_V);
    load(BC_TEXT_ADR, PT_V);
    wr(BC_CTRL_ADR, 8'hA0);
    wait_end();
    rd_chk(BC_STAT_ADR, 8'h01, "status cbc encrypt");
    unload(BC_TEXT_ADR, CT_V, "cbc ciphertext");
    load(BC_KEY_ADR, RK_V);
    load(BC_TEXT_ADR, CT_V);
    wr(BC_CTRL_ADR, 8'hA8);
    wait_end();
    rd_chk(BC_STAT_ADR, 8'h01, "status cbc decrypt");
    unload(BC_TEXT_ADR, PT_V ^ CT_V, "cbc plaintext");
    $display("test cbc done");

    tally_and_finish();
  end
endmodule

// File: verilog/bc_core.sv
// Block cipher register interface with a round-per-cycle core.
// Assumes a byte register port, one clock and a sleep entry strobe.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ns
module bc_core
  import bc_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Register port
  input  wire logic [8:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // System
  input  wire logic       sleep_enter,
  output logic            irq
);

  // ----------------------------------------------------------------
  // Field arithmetic
  // ----------------------------------------------------------------
  function automatic logic [7:0] xt(input logic [7:0] a);
    return {a[6:0], 1'b0} ^ (a[7] ? BC_POLY : 8'h00);
  endfunction
  function automatic logic [7:0] gm(input logic [7:0] a,
                                    input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ x;
      x = xt(x);
    end
    return p;
  endfunction
  // Inverse as a^254; no table, costs area not storage
  function automatic logic [7:0] ginv(input logic [7:0] a);
    logic [7:0] p;
    logic [7:0] q;
    p = a;
    q = 8'h01;
    for (int i = 0; i < 7; i++) begin
      p = gm(p, p);
      q = gm(q, p);
    end
    return q;
  endfunction
  function automatic logic [7:0] sb(input logic [7:0] a);
    logic [7:0] b;
    b = ginv(a);
    return b ^ {b[6:0], b[7]} ^ {b[5:0], b[7:6]} ^ {b[4:0], b[7:5]}
           ^ {b[3:0], b[7:4]} ^ BC_AFF_C;
  endfunction
  function automatic logic [7:0] isb(input logic [7:0] a);
    return ginv({a[6:0], a[7]} ^ {a[4:0], a[7:5]} ^ {a[1:0], a[7:2]}
                ^ BC_IAFF_C);
  endfunction
  function automatic logic [7:0] rcon(input logic [3:0] n);
    logic [7:0] x;
    x = 8'h01;
    for (int i = 1; i < 10; i++) begin
      if (i < n) x = xt(x);
    end
    return x;
  endfunction
  // ----------------------------------------------------------------
  // Round and key schedule steps
  // ----------------------------------------------------------------
  function automatic bc_blk_type mix(input bc_blk_type s,
                                     input logic [3:0][7:0] m);
    bc_blk_type o;
    o = '0;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        for (int j = 0; j < 4; j++) begin
          o[4*c+r] = o[4*c+r] ^ gm(s[4*c+(r+j)%4], m[j]);
        end
      end
    end
    return o;
  endfunction
  function automatic bc_blk_type kexp(input bc_blk_type k,
                                      input logic [7:0] rc);
    bc_blk_type o;
    o = '0;
    for (int j = 0; j < 4; j++) begin
      o[j] = k[j] ^ sb(k[12+(j+1)%4]) ^ ((j == 0) ? rc : 8'h00);
    end
    for (int i = 4; i < 16; i++) begin
      o[i] = k[i] ^ o[i-4];
    end
    return o;
  endfunction
  function automatic bc_blk_type kinv(input bc_blk_type k,
                                      input logic [7:0] rc);
    bc_blk_type o;
    o = '0;
    for (int i = 4; i < 16; i++) begin
      o[i] = k[i] ^ k[i-4];
    end
    for (int j = 0; j < 4; j++) begin
      o[j] = k[j] ^ sb(o[12+(j+1)%4]) ^ ((j == 0) ? rc : 8'h00);
    end
    return o;
  endfunction
  function automatic bc_blk_type enc(input bc_blk_type s,
                                     input bc_blk_type k,
                                     input logic last);
    bc_blk_type t;
    t = '0;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        t[r+4*c] = sb(s[r+4*((c+r)%4)]);
      end
    end
    if (!last) t = mix(t, BC_MIX_ENC);
    return t ^ k;
  endfunction
  function automatic bc_blk_type dec(input bc_blk_type s,
                                     input bc_blk_type k,
                                     input logic last);
    bc_blk_type t;
    t = '0;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        t[r+4*((c+r)%4)] = isb(s[r+4*c]);
      end
    end
    t = t ^ k;
    if (!last) t = mix(t, BC_MIX_DEC);
    return t;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    bc_fsm_type st;
    logic [7:0] ctrl;
    logic       done;
    logic       err;
    bc_blk_type txt;
    bc_blk_type key;
    bc_blk_type rk;
    bc_blk_type acc;
    bc_blk_type chain;
    bc_blk_type cin;
    logic [3:0] tp;
    logic [3:0] kwp;
    logic [3:0] krp;
    logic [3:0] rnd;
    logic       txt_ok;
    logic       key_ok;
    logic [1:0] istat;
    logic [1:0] imask;
    logic [7:0] rdata;
    logic       irq;
  } bc_state_type;
  bc_state_type r;
  bc_state_type n;
  logic         ctl_acc;
  logic         ev_done;
  logic         ev_err;
  logic         last;
  bc_blk_type   rk_n;
  bc_blk_type   res;
  assign reg_rdata = r.rdata;
  assign irq       = r.irq;
  assign ctl_acc   = (reg_rd | reg_wr) && (reg_addr == BC_CTRL_ADR);
  assign last      = (r.rnd == BC_NROUND);
  // Key schedule runs forward on encrypt, backward on decrypt
  assign rk_n = r.ctrl[BC_CTL_DIR]
                ? kinv(r.rk, rcon(4'(BC_NROUND + 4'h1 - r.rnd)))
                : kexp(r.rk, rcon(r.rnd));
  assign res  = r.ctrl[BC_CTL_DIR] ? dec(r.acc, rk_n, last)
                                   : enc(r.acc, rk_n, last);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n       = r;
    ev_done = 1'b0;
    ev_err  = 1'b0;
    n.rdata = 8'h00;
    // Register reads; reserved bits read zero
    if (reg_rd) begin
      case (reg_addr)
        BC_CTRL_ADR:  n.rdata = {r.st == BC_RUN, r.ctrl[6:0]};
        BC_STAT_ADR:  n.rdata = {r.err, 6'h00, r.done};
        BC_ISTAT_ADR: n.rdata = {6'h00, r.istat};
        BC_IMASK_ADR: n.rdata = {6'h00, r.imask};
        BC_TEXT_ADR: begin
          if (r.st == BC_IDLE) begin
            n.rdata = r.txt[r.tp];
            n.tp    = r.tp + 4'h1;
            if (r.tp == BC_LASTB) n.txt_ok = 1'b1;
          end
        end
        BC_KEY_ADR: begin
          n.rdata = r.rk[r.krp];
          n.krp   = r.krp + 4'h1;
        end
        default: n.rdata = 8'h00;
      endcase
    end
    // Register writes; status takes none
    if (reg_wr) begin
      case (reg_addr)
        BC_CTRL_ADR: begin
          n.ctrl = reg_wdata & BC_CTL_WMASK;
          if (reg_wdata[BC_CTL_REQ] && r.st == BC_IDLE) begin
            n.done = 1'b0;
            n.err  = 1'b0;
            if (!(r.key_ok && r.txt_ok && r.tp == 4'h0
                  && r.kwp == 4'h0)) begin
              n.err  = 1'b1;
              ev_err = 1'b1;
            end else begin
              n.st     = BC_RUN;
              n.rnd    = 4'h1;
              n.txt_ok = 1'b0;
              n.cin    = r.txt;
              n.rk     = r.key;
              n.acc    = r.txt ^ r.key;
              if (reg_wdata[BC_CTL_MODE] && !reg_wdata[BC_CTL_DIR])
                n.acc = r.txt ^ r.chain ^ r.key;
            end
          end
        end
        BC_TEXT_ADR: begin
          if (r.st == BC_IDLE) begin
            n.txt[r.tp] = reg_wdata;
            n.tp        = r.tp + 4'h1;
            if (r.tp == BC_LASTB) n.txt_ok = 1'b1;
          end
        end
        BC_KEY_ADR: begin
          if (r.st == BC_IDLE) begin
            n.key[r.kwp] = reg_wdata;
            n.kwp        = r.kwp + 4'h1;
            if (r.kwp == BC_LASTB) n.key_ok = 1'b1;
          end
        end
        BC_ISTAT_ADR: n.istat = r.istat & ~reg_wdata[1:0];
        BC_IMASK_ADR: n.imask = reg_wdata[1:0];
        default: n.imask = n.imask;
      endcase
    end
    // Round engine; a control access wins over the round step
    if (r.st == BC_RUN) begin
      if (ctl_acc) begin
        n.st   = BC_IDLE;
        n.err  = 1'b1;
        ev_err = 1'b1;
      end else begin
        n.acc = res;
        n.rk  = rk_n;
        n.rnd = r.rnd + 4'h1;
        if (last) begin
          n.st    = BC_IDLE;
          n.done  = 1'b1;
          ev_done = 1'b1;
          n.krp   = 4'h0;
          n.txt   = res;
          if (r.ctrl[BC_CTL_MODE]) begin
            n.chain = r.ctrl[BC_CTL_DIR] ? r.cin : res;
            if (r.ctrl[BC_CTL_DIR]) n.txt = res ^ r.chain;
          end
        end
      end
    end
    // Sticky events; a set in the clearing cycle survives
    if (n.ctrl[BC_CTL_IE]) begin
      n.istat[BC_IS_DONE] = n.istat[BC_IS_DONE] | ev_done;
      n.istat[BC_IS_ERR]  = n.istat[BC_IS_ERR] | ev_err;
    end
    // Sleep entry drops control, status and both buffers; istat and imask keep their values
    if (sleep_enter) begin
      n.st     = BC_IDLE;
      n.ctrl   = BC_CTRL_RST;
      n.done   = 1'b0;
      n.err    = 1'b0;
      n.txt    = '0;
      n.key    = '0;
      n.rk     = '0;
      n.chain  = '0;
      n.tp     = 4'h0;
      n.kwp    = 4'h0;
      n.krp    = 4'h0;
      n.txt_ok = 1'b0;
      n.key_ok = 1'b0;
    end
    n.irq = n.ctrl[BC_CTL_IE] & |(n.istat & n.imask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_abort;
    r.st == BC_RUN && ctl_acc && !sleep_enter |=> r.st == BC_IDLE && r.err && !r.done;
  endproperty
  a_abort: assert property (p_abort) else $error("no abort");
  property p_start;
    r.st == BC_IDLE && reg_wr && reg_addr == BC_CTRL_ADR
      && reg_wdata[BC_CTL_REQ] && r.key_ok && r.txt_ok
      && r.tp == 4'h0 && r.kwp == 4'h0 && !sleep_enter
      |=> r.st == BC_RUN && r.rnd == 4'h1 && !r.err ##1 r.rnd == 4'h2;
  endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_done;
    $rose(r.done) |-> $past(r.rnd) == BC_NROUND && $past(r.st) == BC_RUN && !r.err;
  endproperty
  a_done: assert property (p_done) else $error("bad done");
  property p_chain;
    $rose(r.done) && r.ctrl[BC_CTL_MODE] && !r.ctrl[BC_CTL_DIR] |-> r.chain == r.txt;
  endproperty
  a_chain: assert property (p_chain) else $error("bad chain");
  property p_ie;
    !r.ctrl[BC_CTL_IE] |-> !irq;
  endproperty
  a_ie: assert property (p_ie) else $error("irq not gated");
  // Writable bits must land as written, reserved ones as zero
  property p_rsv;
    reg_wr && reg_addr == BC_CTRL_ADR && !sleep_enter
      |=> r.ctrl == ($past(reg_wdata) & BC_CTL_WMASK);
  endproperty
  a_rsv: assert property (p_rsv) else $error("ctrl write");
  property p_stat;
    reg_wr && reg_addr == BC_STAT_ADR && r.st == BC_IDLE && !sleep_enter
      |=> $stable({r.err, r.done});
  endproperty
  a_stat: assert property (p_stat) else $error("status written");
  property p_txt;
    reg_wr && reg_addr == BC_TEXT_ADR && r.st == BC_IDLE && !sleep_enter
      |=> r.tp == 4'($past(r.tp) + 4'h1) && r.txt[$past(r.tp)] == $past(reg_wdata);
  endproperty
  a_txt: assert property (p_txt) else $error("text ptr");
  property p_key;
    reg_wr && reg_addr == BC_KEY_ADR && r.kwp == BC_LASTB
      && r.st == BC_IDLE && !sleep_enter |=> r.key_ok && r.kwp == 4'h0;
  endproperty
  a_key: assert property (p_key) else $error("key load");
  property p_krd;
    reg_rd && reg_addr == BC_KEY_ADR && r.st == BC_IDLE |=> reg_rdata == $past(r.rk[r.krp]);
  endproperty
  a_krd: assert property (p_krd) else $error("key read");
  property p_keep;
    r.st == BC_RUN && !sleep_enter |=> $stable(r.key);
  endproperty
  a_keep: assert property (p_keep) else $error("key changed");
  property p_sleep;
    sleep_enter |=> r.ctrl == 8'h00 && !r.done && !r.err && r.txt == '0 && r.key == '0;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep clear");
  property p_irq;
    $rose(r.done) && r.ctrl[BC_CTL_IE] |-> r.istat[BC_IS_DONE];
  endproperty
  a_irq: assert property (p_irq) else $error("no event");

  c_run:   cover property (r.st == BC_RUN ##10 r.done);
  c_abort: cover property (r.st == BC_RUN && ctl_acc);
  c_cbc:   cover property ($rose(r.done) && r.ctrl[BC_CTL_MODE]);
  c_irq:   cover property ($rose(irq));

endmodule

// File: verilog/bc_pkg.sv
// Package of the block cipher register interface: addresses, field
// positions, reset values and shared types.
// Assumes an 8-bit register port with byte addresses.
package bc_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [8:0] BC_CTRL_ADR  = 9'h13C;
  localparam logic [8:0] BC_STAT_ADR  = 9'h13D;
  localparam logic [8:0] BC_TEXT_ADR  = 9'h13E;
  localparam logic [8:0] BC_KEY_ADR   = 9'h13F;
  localparam logic [8:0] BC_ISTAT_ADR = 9'h140;
  localparam logic [8:0] BC_IMASK_ADR = 9'h141;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         BC_CTL_REQ   = 7;
  localparam int         BC_CTL_MODE  = 5;
  localparam int         BC_CTL_DIR   = 3;
  localparam int         BC_CTL_IE    = 2;
  localparam logic [7:0] BC_CTL_WMASK = 8'h2C;
  localparam int         BC_ST_ERR    = 7;
  localparam int         BC_ST_DONE   = 0;
  localparam int         BC_IS_DONE   = 0;
  localparam int         BC_IS_ERR    = 1;
  localparam logic [7:0] BC_CTRL_RST  = 8'h00;
  localparam logic [1:0] BC_INT_RST   = 2'h0;

  // ----------------------------------------------------------------
  // Cipher constants
  // ----------------------------------------------------------------
  localparam logic [3:0]      BC_NROUND  = 4'hA;
  localparam logic [3:0]      BC_LASTB   = 4'hF;
  localparam logic [7:0]      BC_POLY    = 8'h1B;
  localparam logic [7:0]      BC_AFF_C   = 8'h63;
  localparam logic [7:0]      BC_IAFF_C  = 8'h05;
  localparam logic [3:0][7:0] BC_MIX_ENC = {8'h01, 8'h01, 8'h03, 8'h02};
  localparam logic [3:0][7:0] BC_MIX_DEC = {8'h09, 8'h0D, 8'h0B, 8'h0E};

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [15:0][7:0] bc_blk_type;
  typedef enum logic {BC_IDLE, BC_RUN} bc_fsm_type;

endpackage
